// File: sqs_egress_model.sv
`default_nettype none

module sqs_egress_model import sqs_pkg::*; #(
  parameter int NPORT = 4
) (
  // Clock.
  input wire logic clk,
  // Frame slots of every port.
  input wire logic [NPORT-1:0] tx_valid,
  output logic [NPORT-1:0] tx_ready,
  input wire logic [NPORT*ID_W-1:0] tx_fid,
  input wire logic [NPORT*3-1:0] tx_class,
  // Pace: high makes the far side stall often.
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ns;

  int cnt [NPORT];
  logic [ID_W-1:0] xr [NPORT];
  logic [2:0] log0 [16];
  int seed = 3324;

  // Nothing taken before the first edge.
  initial begin
    tx_ready = '0;
    for (int p = 0; p < NPORT; p++) begin
      cnt[p] = 0;
      xr[p] = '0;
    end
  end

  // Take a slot when both sides agree, log it, then pick the next pace.
  always @(posedge clk) begin
    for (int p = 0; p < NPORT; p++) begin
      if (tx_valid[p] === 1'b1 && tx_ready[p]) begin
        if (p == 0) begin
          log0[cnt[0] % 16] = tx_class[2:0];
        end
        xr[p] = xr[p] ^ tx_fid[p*ID_W +: ID_W];
        cnt[p] = cnt[p] + 1;
      end
      tx_ready[p] <= slow ? (($random(seed) & 3) == 0) : 1'b1;
    end
  end
endmodule : sqs_egress_model

`default_nettype wire

// File: sqs_fifo.sv
`default_nettype none

module sqs_fifo import sqs_pkg::*; #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(D);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (D < 2 || (1 << AW) != D || W < 1) begin : g_bad
    $error("sqs_fifo depth must be a power of two of at least 2.");
  end

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } sqs_fifo_st_t;

  sqs_fifo_st_t s_reg, s_next;
  logic push, pop;

  // Full and empty follow the stored count.
  assign in_ready = (s_reg.cnt != (AW+1)'(D));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data = s_reg.mem[s_reg.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state: write at the tail, read at the head.
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = s_reg.wr + 1'b1;
    end
    if (pop) begin
      s_next.rd = s_reg.rd + 1'b1;
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : sqs_fifo

`default_nettype wire

// File: sqs_pkg.sv
// Function
// - Every frame is stored once per port of its destination set that admits the copy, so only those listed ports receive a copy.
// - All stored copies share one descriptor pool that any queue of any port can use.
// - The queue of a copy is chosen from the egress port and a configurable use of ingress port and class.
// - A copy is admitted only while its queue and its egress port stay below configurable thresholds.
// - Each egress port keeps one queue per ingress port and class and folds them into eight class inputs.
// - Inside a class the ingress queues are served by byte deficit round robin with equal quanta.
// - Among strict classes that are not held, a pending frame of a higher class always leaves before a lower one.
// - Each round robin class has a weight of 0 to 31 that sets its byte quantum and so its share.
// - The strict/round robin split is programmable at any class; after reset classes 7 and 6 are strict.
// - Queue and class stages form a fixed hierarchy; software can hold each class of each port.
`default_nettype none

package sqs_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int CLS_N = 8;
  localparam int ID_W = 8;
  localparam int LEN_W = 11;
  localparam int DEF_W = 16;
  localparam int ADDR_W = 12;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_SPLIT = 12'h004;
  localparam logic [ADDR_W-1:0] REG_WGT_LO = 12'h008;
  localparam logic [ADDR_W-1:0] REG_WGT_HI = 12'h00c;
  localparam logic [ADDR_W-1:0] REG_CMAP = 12'h010;
  localparam logic [ADDR_W-1:0] REG_THR = 12'h014;
  localparam logic [ADDR_W-1:0] REG_HOLD = 12'h018;
  localparam logic [ADDR_W-1:0] REG_STAT = 12'h01c;

  // Control bits and reset values.
  localparam int CTRL_EN = 0;
  localparam int CTRL_USE_IN = 1;
  localparam int CTRL_USE_CLS = 2;
  localparam logic [2:0] CTRL_RST = 3'h7;
  localparam logic [3:0] SPLIT_RST = 4'h6;
  localparam logic [31:0] WGT_RST = 32'h01010101;
  localparam logic [23:0] CMAP_RST = 24'hfac688;
  localparam logic [7:0] QTHR_RST = 8'h08;
  localparam logic [7:0] PTHR_RST = 8'h10;
  localparam int WGT_STRIDE = 8;
  localparam int WGT_W = 5;

  // Byte quantum per unit of weight.
  localparam logic [DEF_W-1:0] QUANT = 16'h0040;

  // ---------------------------------------------------------------
  // Scheduler states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEL = 2'b01,
    ST_SEND = 2'b10
  } sqs_state_t;

endpackage : sqs_pkg

`default_nettype wire

// File: sqs_top.sv
// Register access over APB and the register addresses were decided locally.
`default_nettype none

module sqs_top import sqs_pkg::*; #(
  parameter int NPORT = 4,
  parameter int POOL = 32,
  parameter int FIFO_D = 4
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic ARST_N,
  // APB register port.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Frames from the forwarding analyzer.
  input wire logic RX_VALID,
  output logic RX_READY,
  input wire logic [ID_W-1:0] RX_FID,
  input wire logic [LEN_W-1:0] RX_LEN,
  input wire logic [$clog2(NPORT)-1:0] RX_SRC,
  input wire logic [2:0] RX_CLASS,
  input wire logic [NPORT-1:0] RX_DEST,
  // Frames to the egress transmit paths, one slot per port.
  output logic [NPORT-1:0] TX_VALID,
  input wire logic [NPORT-1:0] TX_READY,
  output logic [NPORT*ID_W-1:0] TX_FID,
  output logic [NPORT*LEN_W-1:0] TX_LEN,
  output logic [NPORT*3-1:0] TX_CLASS,
  output logic [NPORT*$clog2(NPORT)-1:0] TX_SRC
);

  localparam int PW = $clog2(NPORT);
  localparam int SW = $clog2(POOL) + 1;
  localparam int NQ = NPORT * NPORT * CLS_N;
  localparam int NC = NPORT * CLS_N;
  localparam int FW = ID_W + LEN_W + PW + 3 + NPORT;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (!(NPORT == 2 || NPORT == 4) || POOL < 2 || POOL > 64) begin : g_bad
    $error("sqs_top supports 2 or 4 ports and a pool of 2 to 64.");
  end

  typedef struct packed {
    sqs_state_t st;
    logic [PW-1:0] cur;
    logic [2:0] sel_c;
    logic [PW-1:0] sel_i;
    logic have;
    logic [NPORT-1:0] rem;
    logic [POOL-1:0] pv;
    logic [POOL-1:0][PW-1:0] pe;
    logic [POOL-1:0][PW-1:0] pi;
    logic [POOL-1:0][2:0] pc;
    logic [POOL-1:0][ID_W-1:0] pf;
    logic [POOL-1:0][LEN_W-1:0] pl;
    logic [POOL-1:0][SW-1:0] ps;
    logic [NQ-1:0][SW-1:0] head;
    logic [NQ-1:0][SW-1:0] tail;
    logic [NQ-1:0][DEF_W-1:0] idef;
    logic [NC-1:0][DEF_W-1:0] cdef;
    logic [NC-1:0][PW-1:0] iptr;
    logic [NPORT-1:0][2:0] cptr;
    logic [NPORT-1:0][SW-1:0] pcnt;
    logic [NPORT-1:0] txv;
    logic [NPORT-1:0][ID_W-1:0] txf;
    logic [NPORT-1:0][LEN_W-1:0] txl;
    logic [NPORT-1:0][2:0] txc;
    logic [NPORT-1:0][PW-1:0] txs;
    logic [2:0] ctrl;
    logic [3:0] split;
    logic [31:0] wlo;
    logic [31:0] whi;
    logic [23:0] cmap;
    logic [15:0] thr;
    logic [NC-1:0] hold;
    logic [15:0] drops;
    logic [31:0] rdata;
    logic err;
    logic split_wr;
  } sqs_top_st_t;

  sqs_top_st_t s_reg, s_next;
  logic f_valid, f_pop, f_ready;
  logic [FW-1:0] f_data;
  logic [ID_W-1:0] f_fid;
  logic [LEN_W-1:0] f_len;
  logic [PW-1:0] f_src;
  logic [2:0] f_cls;
  logic [NPORT-1:0] f_mask;
  logic [NC-1:0] cls_el;
  logic admit, wr_copy, sp_pick, rr_pick;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic int qix(logic [PW-1:0] e, logic [PW-1:0] i,
                             logic [2:0] c);
    return (int'(e) * NPORT + int'(i)) * CLS_N + int'(c);
  endfunction : qix

  function automatic int cix(logic [PW-1:0] e, logic [2:0] c);
    return int'(e) * CLS_N + int'(c);
  endfunction : cix

  function automatic logic [PW-1:0] lowbit(logic [NPORT-1:0] m);
    logic [PW-1:0] r;
    r = '0;
    for (int k = NPORT - 1; k >= 0; k--) begin
      if (m[k]) r = PW'(k);
    end
    return r;
  endfunction : lowbit

  function automatic logic mapped(logic [ADDR_W-1:0] a);
    return a == REG_CTRL || a == REG_SPLIT || a == REG_WGT_LO ||
           a == REG_WGT_HI || a == REG_CMAP || a == REG_THR ||
           a == REG_HOLD || a == REG_STAT;
  endfunction : mapped

  function automatic logic [DEF_W-1:0] quantum(logic [63:0] w,
                                               logic [2:0] c);
    logic [WGT_W-1:0] q;
    q = w[int'(c)*WGT_STRIDE +: WGT_W];
    if (q == '0) q = WGT_W'(1);
    return DEF_W'(q) * QUANT;
  endfunction : quantum

  // ---------------------------------------------------------------
  // Ingress buffer
  // ---------------------------------------------------------------
  sqs_fifo #(.W(FW), .D(FIFO_D)) u_fifo (
    .clk(CLK),
    .arst_n(ARST_N),
    .in_valid(RX_VALID),
    .in_ready(f_ready),
    .in_data({RX_FID, RX_LEN, RX_SRC, RX_CLASS, RX_DEST}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  assign RX_READY = f_ready;
  assign {f_fid, f_len, f_src, f_cls, f_mask} = f_data;

  // Class is eligible when a queue holds data and the class is not held.
  always_comb begin
    cls_el = '0;
    for (int e = 0; e < NPORT; e++) begin
      for (int c = 0; c < CLS_N; c++) begin
        for (int i = 0; i < NPORT; i++) begin
          if (s_reg.head[(e*NPORT+i)*CLS_N+c] !=
              s_reg.tail[(e*NPORT+i)*CLS_N+c])
            cls_el[e*CLS_N+c] = ~s_reg.hold[e*CLS_N+c];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Next state: register access, enqueue, scheduling
  // ---------------------------------------------------------------
  always_comb begin
    logic [PW-1:0] e, in_map, ci;
    logic [2:0] c_map, c;
    logic found, ok;
    int q, fr, hit, ce;
    logic [SW-1:0] qcnt;
    e = '0; in_map = '0; ci = '0; c_map = '0; c = '0;
    found = 1'b0; ok = 1'b0; q = 0; fr = 0; hit = -1; ce = 0;
    qcnt = '0;
    s_next = s_reg;
    f_pop = 1'b0;
    admit = 1'b0;
    wr_copy = 1'b0;
    sp_pick = 1'b0;
    rr_pick = 1'b0;
    // APB: read data is captured in setup, writes act in access.
    if (PSEL && !PENABLE) begin
      s_next.err = ~mapped(PADDR);
      unique case (PADDR)
        REG_CTRL: s_next.rdata = 32'(s_reg.ctrl);
        REG_SPLIT: s_next.rdata = 32'(s_reg.split);
        REG_WGT_LO: s_next.rdata = s_reg.wlo;
        REG_WGT_HI: s_next.rdata = s_reg.whi;
        REG_CMAP: s_next.rdata = 32'(s_reg.cmap);
        REG_THR: s_next.rdata = 32'(s_reg.thr);
        REG_HOLD: s_next.rdata = 32'(s_reg.hold);
        REG_STAT: s_next.rdata = {s_reg.drops, 8'h00,
                                  8'($countones(s_reg.pv))};
        default: s_next.rdata = '0;
      endcase
    end
    if (PSEL && PENABLE && PWRITE) begin
      unique case (PADDR)
        REG_CTRL: s_next.ctrl = PWDATA[2:0];
        REG_SPLIT: begin
          s_next.split = PWDATA[3:0];
          s_next.split_wr = 1'b1;
        end
        REG_WGT_LO: s_next.wlo = PWDATA;
        REG_WGT_HI: s_next.whi = PWDATA;
        REG_CMAP: s_next.cmap = PWDATA[23:0];
        REG_THR: s_next.thr = PWDATA[15:0];
        REG_HOLD: s_next.hold = PWDATA[NC-1:0];
        default: ;
      endcase
    end
    // Ingress: one copy per cycle, lowest remaining destination port first.
    if (!s_reg.have) begin
      if (f_valid && f_mask == '0) f_pop = 1'b1;
      else if (f_valid) begin
        s_next.have = 1'b1;
        s_next.rem = f_mask;
      end
    end else begin
      e = lowbit(s_reg.rem);
      s_next.rem[e] = 1'b0;
      if ((s_reg.rem & ~(NPORT'(1) << e)) == '0) begin
        f_pop = 1'b1;
        s_next.have = 1'b0;
      end
      in_map = s_reg.ctrl[CTRL_USE_IN] ? f_src : '0;
      c_map = s_reg.ctrl[CTRL_USE_CLS] ?
              s_reg.cmap[int'(f_cls)*3 +: 3] : 3'h0;
      q = qix(e, in_map, c_map);
      qcnt = s_reg.tail[q] - s_reg.head[q];
      for (int k = POOL - 1; k >= 0; k--) begin
        if (!s_reg.pv[k]) begin
          found = 1'b1;
          fr = k;
        end
      end
      admit = found && 8'(qcnt) < s_reg.thr[7:0] &&
              8'(s_reg.pcnt[e]) < s_reg.thr[15:8];
      if (admit) begin
        wr_copy = 1'b1;
        s_next.pv[fr] = 1'b1;
        s_next.pe[fr] = e;
        s_next.pi[fr] = in_map;
        s_next.pc[fr] = c_map;
        s_next.pf[fr] = f_fid;
        s_next.pl[fr] = f_len;
        s_next.ps[fr] = s_reg.tail[q];
        s_next.tail[q] = s_reg.tail[q] + 1'b1;
        s_next.pcnt[e] = s_reg.pcnt[e] + 1'b1;
      end else begin
        s_next.drops = s_reg.drops + 16'h0001;
      end
    end
    // Egress slots empty when the transmit path takes them.
    for (int p = 0; p < NPORT; p++) begin
      if (s_reg.txv[p] && TX_READY[p]) s_next.txv[p] = 1'b0;
    end
    unique case (s_reg.st)
      ST_IDLE: begin
        for (int k = NPORT; k >= 1; k--) begin
          ci = s_reg.cur + PW'(k);
          if (s_reg.ctrl[CTRL_EN] && !s_reg.txv[ci] &&
              cls_el[int'(ci)*CLS_N +: CLS_N] != '0) begin
            s_next.cur = ci;
            s_next.st = ST_SEL;
          end
        end
      end
      ST_SEL: begin
        s_next.st = ST_IDLE;
        // Scan from the top class down so the highest strict class wins.
        for (int k = CLS_N - 1; k >= 0; k--) begin
          if (!sp_pick && k >= int'(s_reg.split) &&
              cls_el[cix(s_reg.cur, 3'(k))]) begin
            sp_pick = 1'b1;
            c = 3'(k);
          end
        end
        if (!sp_pick) begin
          // Weighted classes only when no strict class is ready.
          c = s_reg.cptr[s_reg.cur];
          ce = cix(s_reg.cur, c);
          if (int'(c) < int'(s_reg.split) && cls_el[ce] &&
              $signed(s_reg.cdef[ce]) > 0) begin
            rr_pick = 1'b1;
          end else begin
            if (int'(c) < int'(s_reg.split) && cls_el[ce])
              s_next.cdef[ce] = s_reg.cdef[ce] +
                                quantum({s_reg.whi, s_reg.wlo}, c);
            else s_next.cdef[ce] = '0;
            s_next.cptr[s_reg.cur] = c + 3'h1;
          end
        end
        if (sp_pick || rr_pick) begin
          ce = cix(s_reg.cur, c);
          ci = s_reg.iptr[ce];
          q = qix(s_reg.cur, ci, c);
          ok = s_reg.head[q] != s_reg.tail[q];
          if (ok && $signed(s_reg.idef[q]) > 0) begin
            s_next.sel_c = c;
            s_next.sel_i = ci;
            s_next.st = ST_SEND;
          end else begin
            // Equal quantum for every ingress queue of the class.
            s_next.idef[q] = ok ? s_reg.idef[q] + QUANT : '0;
            s_next.iptr[ce] = ci + 1'b1;
          end
        end
      end
      ST_SEND: begin
        s_next.st = ST_IDLE;
        q = qix(s_reg.cur, s_reg.sel_i, s_reg.sel_c);
        ce = cix(s_reg.cur, s_reg.sel_c);
        for (int k = 0; k < POOL; k++) begin
          if (s_reg.pv[k] && s_reg.pe[k] == s_reg.cur &&
              s_reg.pi[k] == s_reg.sel_i && s_reg.pc[k] == s_reg.sel_c &&
              s_reg.ps[k] == s_reg.head[q])
            hit = k;
        end
        if (hit >= 0) begin
          s_next.pv[hit] = 1'b0;
          s_next.txv[s_reg.cur] = 1'b1;
          s_next.txf[s_reg.cur] = s_reg.pf[hit];
          s_next.txl[s_reg.cur] = s_reg.pl[hit];
          s_next.txc[s_reg.cur] = s_reg.sel_c;
          s_next.txs[s_reg.cur] = s_reg.sel_i;
          s_next.head[q] = s_reg.head[q] + 1'b1;
          s_next.pcnt[s_reg.cur] = s_next.pcnt[s_reg.cur] - 1'b1;
          s_next.idef[q] = s_next.idef[q] - DEF_W'(s_reg.pl[hit]);
          if (int'(s_reg.sel_c) < int'(s_reg.split))
            s_next.cdef[ce] = s_reg.cdef[ce] -
                              DEF_W'(s_reg.pl[hit]);
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  // State register with documented reset values.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RST;
      s_reg.split <= SPLIT_RST;
      s_reg.wlo <= WGT_RST;
      s_reg.whi <= WGT_RST;
      s_reg.cmap <= CMAP_RST;
      s_reg.thr <= {PTHR_RST, QTHR_RST};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs.
  assign PRDATA = s_reg.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & s_reg.err;
  assign TX_VALID = s_reg.txv;
  assign TX_FID = s_reg.txf;
  assign TX_LEN = s_reg.txl;
  assign TX_CLASS = s_reg.txc;
  assign TX_SRC = s_reg.txs;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence sel_step;
    s_reg.st == ST_SEL ##1 s_reg.st == ST_SEND;
  endsequence

  sequence send_step;
    s_reg.st == ST_IDLE && $rose(TX_VALID[s_reg.cur]);
  endsequence

  a_copy_done: assert property (
    f_pop |-> $countones(s_reg.rem) <= 1)
    else $error("Frame left the buffer before all copies were made.");
  a_pool_shared: assert property (
    wr_copy |=> $countones(s_reg.pv) == $countones($past(s_reg.pv)) + 1
                || s_reg.st == ST_IDLE)
    else $error("Admitted copy did not take a pool entry.");
  a_thr_admit: assert property (
    wr_copy |-> 8'(s_reg.pcnt[lowbit(s_reg.rem)]) < s_reg.thr[15:8])
    else $error("Copy admitted above the port threshold.");
  a_sel_send: assert property (
    sel_step |=> send_step)
    else $error("Selected queue produced no frame.");
  // The strict class handed to the send step has no eligible class above.
  a_strict_first: assert property (
    sp_pick && s_next.st == ST_SEND |->
      (cls_el[int'(s_reg.cur)*CLS_N +: CLS_N] >>
       (int'(s_next.sel_c) + 1)) == '0)
    else $error("Lower strict class chosen over a higher one.");
  a_rr_last: assert property (
    rr_pick |-> (cls_el[int'(s_reg.cur)*CLS_N +: CLS_N] >>
                 s_reg.split) == '0)
    else $error("Weighted class served while a strict class waits.");
  a_split_reset: assert property (
    !s_reg.split_wr |-> s_reg.split == SPLIT_RST)
    else $error("Strict split lost its reset value.");
  a_tx_hold: assert property (
    TX_VALID[0] && !TX_READY[0] |=> TX_VALID[0] && $stable(TX_FID[ID_W-1:0]))
    else $error("Egress slot changed before it was taken.");

endmodule : sqs_top

`default_nettype wire

// File: test_shared_queue_egress_scheduler.sv
`default_nettype none

module test_shared_queue_egress_scheduler import sqs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, slow;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e, rx_valid, rx_ready, seen_full;
  logic [ID_W-1:0] rx_fid, f;
  logic [LEN_W-1:0] rx_len;
  logic [1:0] rx_src;
  logic [2:0] rx_class;
  logic [3:0] rx_dest, tx_valid, tx_ready, m;
  logic [31:0] tx_fid;
  logic [11:0] tx_class;
  int mismatches, comparisons, cyc, seed, base;
  int exp_n [4];
  logic [ID_W-1:0] exp_x [4];
  logic [ADDR_W-1:0] ra [8] = '{REG_CTRL, REG_SPLIT, REG_WGT_LO,
    REG_WGT_HI, REG_CMAP, REG_THR, REG_HOLD, REG_STAT};
  logic [31:0] rv [8] = '{{29'h0, CTRL_RST}, {28'h0, SPLIT_RST}, WGT_RST,
    WGT_RST, {8'h0, CMAP_RST}, {16'h0, PTHR_RST, QTHR_RST}, 32'h0, 32'h0};
  logic [2:0] sc [4] = '{3'h3, 3'h0, 3'h5, 3'h2};
  logic [2:0] so [4] = '{3'h5, 3'h3, 3'h2, 3'h0};

  sqs_top #(.NPORT(4), .POOL(32), .FIFO_D(4)) DUT (.CLK(clk),
    .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RX_VALID(rx_valid), .RX_READY(rx_ready),
    .RX_FID(rx_fid), .RX_LEN(rx_len), .RX_SRC(rx_src),
    .RX_CLASS(rx_class), .RX_DEST(rx_dest), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .TX_FID(tx_fid), .TX_LEN(), .TX_CLASS(tx_class),
    .TX_SRC());

  sqs_egress_model #(.NPORT(4)) em (.clk(clk), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_fid(tx_fid), .tx_class(tx_class), .slow(slow));

  // Clock of 100 ns period.
  always #50 clk = ~clk;

  // Hang guard and full-FIFO watch.
  always @(posedge clk) begin
    cyc++;
    if (rx_ready === 1'b0) begin
      seen_full = 1'b1;
    end
    if (cyc == 80000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One frame offered until taken; released fid and dest lines show the inverse.
  task automatic send(input logic [ID_W-1:0] fi, input logic [1:0] s,
                      input logic [2:0] c, input logic [3:0] m);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_fid <= fi;
    rx_src <= s;
    rx_class <= c;
    rx_dest <= m;
    rx_len <= 11'h040 + 11'($random(seed) & 32'h1ff);
    do begin
      @(posedge clk);
    end while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_fid <= ~fi;
    rx_dest <= ~m;
  endtask : send

  // Expected copies: one per set bit of the destination set.
  function automatic void add(input logic [ID_W-1:0] fi,
                              input logic [3:0] m);
    for (int p = 0; p < 4; p++) begin
      if (m[p]) begin
        exp_n[p]++;
        exp_x[p] ^= fi;
      end
    end
  endfunction : add

  function automatic logic settled();
    settled = 1'b1;
    for (int p = 0; p < 4; p++) begin
      settled &= (em.cnt[p] == exp_n[p]);
    end
  endfunction : settled

  task automatic drain();
    int n;
    n = 0;
    while (!settled() && n < 12000) begin
      @(posedge clk);
      n++;
    end
    check(32'(settled()), 32'h1);
  endtask : drain

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // Main sequence.
  initial begin
    clk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
    pwdata = '0; rx_valid = 0; rx_fid = '0; rx_len = '0; rx_src = '0;
    rx_class = '0; rx_dest = '0; slow = 0; seed = 3324; seen_full = 0;
    for (int p = 0; p < 4; p++) begin
      exp_n[p] = 0;
      exp_x[p] = '0;
    end
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ra[i], 32'h0);
      check(r, rv[i]);
    end
    apb(1'b1, 12'h020, 32'hffffffff);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    check({r[30:0], e}, 32'h1);
    apb(1'b1, REG_STAT, 32'hffffffff);
    apb(1'b0, REG_STAT, 32'h0);
    check(r, 32'h0);
    // Multicast burst into a stopped scheduler fills the FIFO.
    apb(1'b1, REG_CTRL, 32'h6);
    for (int i = 1; i < 7; i++) begin
      send(ID_W'(i), 2'(i), 3'h1, 4'hf);
      add(ID_W'(i), 4'hf);
    end
    // Let the frames still in the buffer finish their copies.
    repeat (30) @(posedge clk);
    check({31'h0, seen_full}, 32'h1);
    apb(1'b0, REG_STAT, 32'h0);
    check(r, 32'h18);
    apb(1'b1, REG_CTRL, 32'h7);
    drain();
    // Split at class 2: strict highest first, round robin last.
    slow <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h6);
    apb(1'b1, REG_SPLIT, 32'h2);
    for (int i = 0; i < 4; i++) begin
      send(ID_W'(8'h20 + i), 2'h0, sc[i], 4'h1);
      add(ID_W'(8'h20 + i), 4'h1);
    end
    base = em.cnt[0];
    apb(1'b1, REG_CTRL, 32'h7);
    drain();
    for (int i = 0; i < 4; i++) begin
      check(32'(em.log0[(base + i) % 16]), 32'(so[i]));
    end
    apb(1'b1, REG_SPLIT, 32'h6);
    // Queue threshold of two drops the third and fourth copy.
    apb(1'b1, REG_CTRL, 32'h6);
    apb(1'b1, REG_THR, 32'h1002);
    for (int i = 0; i < 4; i++) begin
      send(ID_W'(8'h30 + i), 2'h1, 3'h4, 4'h2);
      if (i < 2) begin
        add(ID_W'(8'h30 + i), 4'h2);
      end
    end
    repeat (8) @(posedge clk);
    apb(1'b0, REG_STAT, 32'h0);
    check(r, 32'h00020002);
    apb(1'b1, REG_THR, 32'h1008);
    apb(1'b1, REG_CTRL, 32'h7);
    drain();
    // Random traffic, empty sets included, fast far side.
    slow <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      f = ID_W'($random(seed));
      m = 4'($random(seed));
      send(f, 2'($random(seed)), 3'($random(seed)), m);
      add(f, m);
      repeat (100) @(posedge clk);
    end
    drain();
    for (int p = 0; p < 4; p++) begin
      check(32'(em.xr[p]), 32'(exp_x[p]));
    end
    apb(1'b0, REG_STAT, 32'h0);
    check(r, 32'h00020000);
    complete_run();
  end
endmodule : test_shared_queue_egress_scheduler

`default_nettype wire
